// file: core/tap_pkg.sv
// Constants and types shared by the boundary-scan access port controller
package tap_pkg;

    // ------------------------------------------------------------
    // Controller states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RESET      = 4'b0000,
        ST_IDLE       = 4'b0001,
        ST_SEL_DR     = 4'b0010,
        ST_CAPTURE_DR = 4'b0011,
        ST_SHIFT_DR   = 4'b0100,
        ST_EXIT1_DR   = 4'b0101,
        ST_PAUSE_DR   = 4'b0110,
        ST_EXIT2_DR   = 4'b0111,
        ST_UPDATE_DR  = 4'b1000,
        ST_SEL_IR     = 4'b1001,
        ST_CAPTURE_IR = 4'b1010,
        ST_SHIFT_IR   = 4'b1011,
        ST_EXIT1_IR   = 4'b1100,
        ST_PAUSE_IR   = 4'b1101,
        ST_EXIT2_IR   = 4'b1110,
        ST_UPDATE_IR  = 4'b1111
    } tap_state_t;

    // ------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------
    localparam int IR_LEN = 3;
    localparam logic [IR_LEN-1:0] IR_CAPTURE_PATTERN = 3'h4;
    localparam logic [IR_LEN-1:0] INSN_EXTEST = 3'h0;
    localparam logic [IR_LEN-1:0] INSN_IDCODE = 3'h1;
    localparam logic [IR_LEN-1:0] INSN_SAMPLE = 3'h2;
    localparam logic [IR_LEN-1:0] INSN_BYPASS = 3'h7;

    // ------------------------------------------------------------
    // Data registers
    // ------------------------------------------------------------
    localparam int ID_LEN = 32;
    localparam logic BYPASS_CAPTURE = 1'b0;
    localparam int BSR_LEN_DEFAULT = 16;

endpackage

// file: core/tap_controller.sv
// Boundary-scan test access port controller with IR and DR scan paths
`timescale 1ns/1ns

// Summary of operation
// (R1) Sixteen-state machine stepped by TMS sampled on each rising TCK edge.
// (R2) Reset state disables test logic, normal operation, instruction becomes IDCODE.
// (R3) Five rising TCK edges with TMS high reach reset from anywhere.
// (R4) Reset state holds while TMS stays high.
// (R5) Controller starts in reset state at power-up.
// (R6) Idle state holds while TMS is low.
// (R7) In idle, instruction and all data registers hold their contents.
// (R8) Idle with TMS high moves to select-DR.
// (R9) Select-DR with TMS low moves to capture-DR, starting a DR scan.
// (R10) Select-DR with TMS high moves to select-IR.
// (R11) Capture-DR loads boundary register from pins only under EXTEST or SAMPLE.
// (R12) Data registers lacking parallel inputs keep contents in capture-DR.
// (R13) Capture-DR goes to exit1-DR on TMS high, shift-DR on low.
// (R14) Shift-DR moves selected register one stage from TDI toward TDO.
// (R15) Shift-DR stays on TMS low, goes to exit1-DR on TMS high.
// (R16) Instruction is unchanged in select, capture and shift DR states.
// (R17) Exit1-DR goes to update-DR on TMS high, pause-DR on low.
// (R18) Boundary latched output updates on falling TCK in update-DR only.
// (R19) Capture-IR loads the pattern 100 into the instruction shifter.
// (R20) TDO is driven only while a register is being shifted.
module tap_controller
    import tap_pkg::*;
#(
    parameter int BSR_LEN = tap_pkg::BSR_LEN_DEFAULT,
    // Arbitrary identification value; bit 0 must stay 1
    parameter logic [tap_pkg::ID_LEN-1:0] ID_CODE = 32'h0000_0001
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic [BSR_LEN-1:0] pins_in,
    output logic tdo,
    output logic tdo_oe,
    output logic [BSR_LEN-1:0] bsr_out,
    output logic test_reset,
    output logic extest_en
);
    import tap_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers and TCK edge detection
    // ------------------------------------------------------------
    logic tck_meta_reg, tck_sync_reg, tck_last_reg;
    logic tms_meta_reg, tms_sync_reg;
    logic tdi_meta_reg, tdi_sync_reg;
    logic [BSR_LEN-1:0] pins_meta_reg, pins_sync_reg;
    logic tck_rise, tck_fall;

    // TCK is only sampled here, so the tester must keep it well below clk/4
    always_ff @(posedge clk)
    begin
        tck_meta_reg <= tck;
        tck_sync_reg <= tck_meta_reg;
        tck_last_reg <= tck_sync_reg;
        tms_meta_reg <= tms;
        tms_sync_reg <= tms_meta_reg;
        tdi_meta_reg <= tdi;
        tdi_sync_reg <= tdi_meta_reg;
        pins_meta_reg <= pins_in;
        pins_sync_reg <= pins_meta_reg;
    end

    always_comb
    begin
        tck_rise = tck_sync_reg & ~tck_last_reg;
        tck_fall = ~tck_sync_reg & tck_last_reg;
    end

    // ------------------------------------------------------------
    // Controller state and scan registers
    // ------------------------------------------------------------
    tap_state_t state_reg, state_next;
    logic [IR_LEN-1:0] ir_reg, ir_next;
    logic [IR_LEN-1:0] ir_shift_reg, ir_shift_next;
    logic bypass_reg, bypass_next;
    logic [ID_LEN-1:0] id_shift_reg, id_shift_next;
    logic [BSR_LEN-1:0] bsr_shift_reg, bsr_shift_next;
    logic [BSR_LEN-1:0] bsr_out_reg, bsr_out_next;
    logic tdo_reg, tdo_next;
    logic tdo_oe_reg, tdo_oe_next;
    logic test_reset_reg, test_reset_next;
    logic extest_reg, extest_next;
    logic bsr_selected;
    logic id_selected;
    logic dr_serial_out;

    always_comb
    begin
        bsr_selected = (ir_reg == INSN_EXTEST) || (ir_reg == INSN_SAMPLE);
        id_selected = (ir_reg == INSN_IDCODE);
        // Unknown instructions fall back to the one-bit bypass path
        if (bsr_selected)
            dr_serial_out = bsr_shift_reg[0];
        else if (id_selected)
            dr_serial_out = id_shift_reg[0];
        else
            dr_serial_out = bypass_reg;
    end

    always_comb
    begin
        // Holding by default keeps every register still outside its own states
        state_next = state_reg;
        ir_next = ir_reg; // (R7) (R16)
        ir_shift_next = ir_shift_reg;
        bypass_next = bypass_reg;
        id_shift_next = id_shift_reg; // (R12)
        bsr_shift_next = bsr_shift_reg;
        bsr_out_next = bsr_out_reg;
        tdo_next = tdo_reg;
        tdo_oe_next = tdo_oe_reg;

        if (tck_rise)
        begin
            unique case (state_reg) // (R1)
                ST_RESET:
                    state_next = tms_sync_reg ? ST_RESET : ST_IDLE; // (R4)
                ST_IDLE:
                    state_next = tms_sync_reg ? ST_SEL_DR : ST_IDLE; // (R6) (R8)
                ST_SEL_DR:
                    state_next = tms_sync_reg ? ST_SEL_IR : ST_CAPTURE_DR; // (R9) (R10)
                ST_CAPTURE_DR:
                begin
                    state_next = tms_sync_reg ? ST_EXIT1_DR : ST_SHIFT_DR; // (R13)
                    if (bsr_selected)
                        bsr_shift_next = pins_sync_reg; // (R11)
                    else if (id_selected)
                        id_shift_next = ID_CODE;
                    else
                        bypass_next = BYPASS_CAPTURE;
                end
                ST_SHIFT_DR:
                begin
                    state_next = tms_sync_reg ? ST_EXIT1_DR : ST_SHIFT_DR; // (R15)
                    if (bsr_selected)
                        bsr_shift_next = {tdi_sync_reg, bsr_shift_reg[BSR_LEN-1:1]}; // (R14)
                    else if (id_selected)
                        id_shift_next = {tdi_sync_reg, id_shift_reg[ID_LEN-1:1]}; // (R14)
                    else
                        bypass_next = tdi_sync_reg; // (R14)
                end
                ST_EXIT1_DR:
                    state_next = tms_sync_reg ? ST_UPDATE_DR : ST_PAUSE_DR; // (R17)
                ST_PAUSE_DR:
                    state_next = tms_sync_reg ? ST_EXIT2_DR : ST_PAUSE_DR;
                ST_EXIT2_DR:
                    state_next = tms_sync_reg ? ST_UPDATE_DR : ST_SHIFT_DR;
                ST_UPDATE_DR:
                    state_next = tms_sync_reg ? ST_SEL_DR : ST_IDLE;
                ST_SEL_IR:
                    state_next = tms_sync_reg ? ST_RESET : ST_CAPTURE_IR; // (R3)
                ST_CAPTURE_IR:
                begin
                    state_next = tms_sync_reg ? ST_EXIT1_IR : ST_SHIFT_IR;
                    ir_shift_next = IR_CAPTURE_PATTERN; // (R19)
                end
                ST_SHIFT_IR:
                begin
                    state_next = tms_sync_reg ? ST_EXIT1_IR : ST_SHIFT_IR;
                    ir_shift_next = {tdi_sync_reg, ir_shift_reg[IR_LEN-1:1]};
                end
                ST_EXIT1_IR:
                    state_next = tms_sync_reg ? ST_UPDATE_IR : ST_PAUSE_IR;
                ST_PAUSE_IR:
                    state_next = tms_sync_reg ? ST_EXIT2_IR : ST_PAUSE_IR;
                ST_EXIT2_IR:
                    state_next = tms_sync_reg ? ST_UPDATE_IR : ST_SHIFT_IR;
                ST_UPDATE_IR:
                    state_next = tms_sync_reg ? ST_SEL_DR : ST_IDLE;
            endcase
        end

        if (tck_fall)
        begin
            if (state_reg == ST_UPDATE_DR && bsr_selected)
                bsr_out_next = bsr_shift_reg; // (R18)
            if (state_reg == ST_UPDATE_IR)
                ir_next = ir_shift_reg;
            // TDO changes on falling TCK so the tester samples a stable bit
            if (state_reg == ST_SHIFT_DR)
            begin
                tdo_next = dr_serial_out; // (R20)
                tdo_oe_next = 1'b1;
            end
            else if (state_reg == ST_SHIFT_IR)
            begin
                tdo_next = ir_shift_reg[0]; // (R20)
                tdo_oe_next = 1'b1;
            end
            else
            begin
                tdo_next = 1'b0;
                tdo_oe_next = 1'b0; // (R20)
            end
        end

        if (state_reg == ST_RESET)
            ir_next = INSN_IDCODE; // (R2)

        test_reset_next = (state_next == ST_RESET); // (R2)
        extest_next = (state_next != ST_RESET) && (ir_next == INSN_EXTEST); // (R2)
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_reg <= ST_RESET; // (R5)
            ir_reg <= INSN_IDCODE;
            ir_shift_reg <= IR_CAPTURE_PATTERN;
            bypass_reg <= BYPASS_CAPTURE;
            id_shift_reg <= ID_CODE;
            bsr_shift_reg <= '0;
            bsr_out_reg <= '0;
            tdo_reg <= 1'b0;
            tdo_oe_reg <= 1'b0;
            test_reset_reg <= 1'b1;
            extest_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            ir_reg <= ir_next;
            ir_shift_reg <= ir_shift_next;
            bypass_reg <= bypass_next;
            id_shift_reg <= id_shift_next;
            bsr_shift_reg <= bsr_shift_next;
            bsr_out_reg <= bsr_out_next;
            tdo_reg <= tdo_next;
            tdo_oe_reg <= tdo_oe_next;
            test_reset_reg <= test_reset_next;
            extest_reg <= extest_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign tdo = tdo_reg;
    assign tdo_oe = tdo_oe_reg;
    assign bsr_out = bsr_out_reg;
    assign test_reset = test_reset_reg;
    assign extest_en = extest_reg;

endmodule

// file: verification/tap_controller_props.sv
// Assertion checker for the boundary-scan port controller
`timescale 1ns/1ns
module tap_controller_props #(
    parameter int BSR_LEN = 16
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic [BSR_LEN-1:0] bsr_out,
    input wire logic test_reset,
    input wire logic extest_en
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // A serial bit must hold for at least five system clock cycles
    sequence s_bit_hold;
        $stable(tdo) [*5];
    endsequence
    a_power_up_reset: assert property (disable iff (1'b0) sys_rst |=> test_reset)
        else $error("not in reset after system reset");
    a_reset_tdo_off: assert property (test_reset |-> !tdo_oe) else $error("tdo on in reset");
    a_idle_tdo_low: assert property (!tdo_oe |-> !tdo) else $error("tdo active undriven");
    a_reset_no_extest: assert property (test_reset |-> !extest_en) else $error("extest");
    a_bsr_update_only: assert property ($changed(bsr_out) |-> !tdo_oe && !test_reset)
        else $error("boundary output moved outside update");
    a_insn_steady_shift: assert property ($changed(extest_en) |-> !tdo_oe)
        else $error("instruction moved while shifting");
    a_tdo_bit_hold: assert property ($changed(tdo) && tdo_oe |=> s_bit_hold)
        else $error("tdo bit too short");
    a_reset_hold: assert property ($rose(test_reset) |=> test_reset [*4])
        else $error("reset state left early");
endmodule
bind tap_controller tap_controller_props #(.BSR_LEN(BSR_LEN)) tap_controller_props_i (
    .clk(clk), .sys_rst(sys_rst), .tdo(tdo), .tdo_oe(tdo_oe), .bsr_out(bsr_out),
    .test_reset(test_reset), .extest_en(extest_en));

// file: verification/tap_tester.sv
// Behavioural model of the external boundary-scan tester
`timescale 1ns/1ns
module tap_tester (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    initial {tck, tms, tdi} = 3'h2;
    // One 800 ns test clock; tck rests low between steps, and each tck edge lands 37 ns
    // before a rising system clock edge, and tdo is taken well inside the high phase
    task automatic step(input logic m, input logic d, output logic q, output logic e);
        tms = m;
        tdi = d;
        #363 tck = 1'b1;
        #200 {q, e} = {tdo, tdo_oe};
        #200 tck = 1'b0;
        #37;
    endtask
endmodule

// file: verification/jtag_tap_controller_dr_path_tb.sv
// Self-checking bench for the boundary-scan port controller
`timescale 1ns/1ns
module jtag_tap_controller_dr_path_tb;
    import tap_pkg::*;
    // Arbitrary identification value, bit 0 set
    localparam logic [31:0] ID = 32'h5a3c_0f01;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] pins_in = 16'h0000, bsr_out;
    logic tck, tms, tdi, tdo, tdo_oe, test_reset, extest_en, q, e;
    logic [31:0] d;
    int fails = 0, comparisons = 0;
    always #50 clk = ~clk;
    tap_controller #(.BSR_LEN(16), .ID_CODE(ID)) tap_controller_i (
        .clk(clk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi), .pins_in(pins_in),
        .tdo(tdo), .tdo_oe(tdo_oe), .bsr_out(bsr_out), .test_reset(test_reset),
        .extest_en(extest_en));
    tap_tester tap_tester_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] y);
        comparisons++;
        if (y !== x)
            $display("wrong value %s expected %h seen %h", s, x, y);
        fails += int'(y !== x);
    endtask
    task automatic end_of_test;
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic st(input logic m, input logic dn);
        tap_tester_i.step(m, dn, q, e);
    endtask
    // Walks one scan from idle back to idle, shifting LSB first
    task automatic scan(input logic ir, input int n, input logic [31:0] din);
        st(1'b1, 1'b0);
        if (ir)
            st(1'b1, 1'b0);
        repeat (2) st(1'b0, 1'b0);
        for (int i = 0; i < n; i++)
        begin
            st(i == n - 1, din[i]);
            d[i] = q;
            chk("oe", 1'b1, e);
        end
        st(1'b1, 1'b0);
        chk("oe", 1'b0, e);
        st(1'b0, 1'b0);
    endtask
    task automatic t_idle_idcode;
        chk("reset", 1'b1, test_reset);
        chk("extest", 1'b0, extest_en);
        repeat (3) st(1'b0, 1'b0);
        chk("reset", 1'b0, test_reset);
        scan(1'b0, 32, 32'h0);
        chk("idcode", ID, d);
        chk("bsr", 16'h0, bsr_out);
    endtask
    task automatic t_boundary;
        @(posedge clk) pins_in <= 16'hc35a;
        scan(1'b1, 3, {29'h0, INSN_SAMPLE});
        chk("ir", IR_CAPTURE_PATTERN, d[2:0]);
        scan(1'b0, 16, 32'h96e1);
        chk("pins", 16'hc35a, d[15:0]);
        chk("bsr", 16'h96e1, bsr_out);
        scan(1'b1, 3, {29'h0, INSN_EXTEST});
        chk("extest", 1'b1, extest_en);
        st(1'b1, 1'b0);
        repeat (2) st(1'b0, 1'b0);
        chk("bsr", 16'h96e1, bsr_out);
        repeat (5) st(1'b1, 1'b0);
        chk("reset", 1'b1, test_reset);
        chk("extest", 1'b0, extest_en);
        st(1'b0, 1'b0);
        scan(1'b0, 32, 32'hffff_ffff);
        chk("idcode", ID, d);
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
        t_idle_idcode();
        t_boundary();
        end_of_test();
    end
endmodule
